// *** core/pdhs_pkg.sv ***
package pdhs_pkg;
  // Notes on behaviour
  // RULE1: Switch stays off and open for as long as lockout is asserted.
  // RULE2: While off, switch output and return rail stay disconnected, no switching.
  // RULE3: Switch never closes before a full detection and classification sequence.
  // RULE4: Enabling the switch always enters the charge-limited state first.
  // RULE5: Charge-limited state drives the switch in closed-loop current limit.
  // RULE6: Charge-limited goes to on when switch drop falls below the low threshold.
  // RULE7: On goes to fault-limited when drop stays above high threshold for qualifying time.
  // RULE8: Fault-limited state holds the switch in low current limit.
  // RULE9: Fault-limited returns to on only below re-close threshold after dwell time.
  // RULE10: Surge clamp only when rail voltage is over threshold and switch is open.
  // RULE11: Ringing detection closes the ringing absorption switch across the rails.
  // RULE12: Detection signature shown while port voltage is within detection range; the code shows it only in the detect state.
  // RULE13: Class current is sunk once the port rises above the class threshold.
  // RULE14: Sourcing side may drop below mark level and raise again before power-on.
  // RULE15: Overcurrent holds the converter in reset until the condition clears.
  // RULE16: After overcurrent clears the converter restarts through soft start.
  // RULE17: Converter start-up is fixed, has no configuration input, uses soft start.
  // RULE18: Converter skips cycles at low load and during a short circuit.
  // RULE19: Fixed oscillator when frequency pin is tied to rail, else tuned one.
  // RULE20: Lockout releases at the rising threshold and asserts at the falling one.
  // RULE21: Comparators sampled on the free clock; intervals timed by counters.
  // RULE22: Lockout in any state forces the switch back to off at once.

  localparam int CLK_PERIOD_NS = 50;
  localparam int QUAL_TIME_US = 140;
  localparam int QUAL_CYC = (QUAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUAL_W = $clog2(QUAL_CYC);
  localparam int DWELL_TIME_MS = 80;
  localparam int DWELL_CYC = (DWELL_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFTSTART_TIME_MS = 4;
  localparam int SOFTSTART_CYC =
    (SOFTSTART_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_EVENTS = 8'h08;

  localparam int CTRL_PERMIT_BIT = 0;
  localparam logic CTRL_PERMIT_RST = 1'b1;

  localparam int ST_SW_LSB = 0;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_SEQ_BIT = 3;
  localparam int ST_CRST_BIT = 4;
  localparam int ST_SS_BIT = 5;
  localparam int ST_CLAMP_BIT = 6;
  localparam int ST_RING_BIT = 7;

  localparam int EV_W = 4;
  localparam int EV_FAULT_BIT = 0;
  localparam int EV_OC_BIT = 1;
  localparam int EV_LOCK_BIT = 2;
  localparam int EV_ON_BIT = 3;

  typedef enum logic [1:0] {SW_OFF, SW_CHARGE, SW_ON, SW_FAULT} pdhs_sw_e;
  typedef enum logic [2:0] {SQ_IDLE, SQ_DETECT, SQ_CLASS, SQ_MARK, SQ_DONE} pdhs_sq_e;
endpackage : pdhs_pkg

// *** core/pdhs_seq_if.sv ***
`timescale 1ns/1ps
interface pdhs_seq_if;
  logic det_range;
  logic above_class;
  logic below_mark;
  logic power_ok;
  logic det_en;
  logic class_en;
  logic done;
  modport seq (input det_range, above_class, below_mark, power_ok,
               output det_en, class_en, done);
  modport ctl (output det_range, above_class, below_mark, power_ok,
               input det_en, class_en, done);
endinterface : pdhs_seq_if

// *** core/pdhs_seq.sv ***
`timescale 1ns/1ps
module pdhs_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  pdhs_seq_if.seq sq
);
  import pdhs_pkg::*;

  typedef struct packed {
    pdhs_sq_e st;
    logic det_en;
    logic class_en;
    logic done;
  } pdhs_seq_s;

  pdhs_seq_s s_r;
  pdhs_seq_s s_nxt;
  logic port_low;

  always_comb begin
    s_nxt = s_r;
    // Below mark and outside detection means the cable is unpowered
    port_low = sq.below_mark && !sq.det_range;
    unique case (s_r.st)
      SQ_IDLE: begin
        if (sq.det_range) s_nxt.st = SQ_DETECT;
      end
      SQ_DETECT: begin
        if (sq.above_class) s_nxt.st = SQ_CLASS;
        else if (port_low) s_nxt.st = SQ_IDLE;
      end
      SQ_CLASS: begin
        if (sq.power_ok) s_nxt.st = SQ_DONE;
        else if (sq.below_mark) s_nxt.st = SQ_MARK; // see RULE14
      end
      SQ_MARK: begin
        if (sq.above_class) s_nxt.st = SQ_CLASS; // see RULE14
        else if (port_low) s_nxt.st = SQ_IDLE;
      end
      SQ_DONE: begin
        if (port_low) s_nxt.st = SQ_IDLE;
      end
    endcase
    s_nxt.det_en = (s_nxt.st == SQ_DETECT) && sq.det_range; // see RULE12
    s_nxt.class_en = (s_nxt.st == SQ_CLASS) && sq.above_class && !sq.power_ok; // see RULE13
    s_nxt.done = (s_nxt.st == SQ_DONE);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: SQ_IDLE, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign sq.det_en = s_r.det_en;
  assign sq.class_en = s_r.class_en;
  assign sq.done = s_r.done;

  default clocking scb @(posedge clk iff ce); endclocking
  default disable iff (!rst_n);

  AST_DET_SIG: assert property (sq.det_en |-> $past(sq.det_range) && s_r.st == SQ_DETECT) // see RULE12
    else $error("signature shown outside detection");
  AST_CLASS_SINK: assert property (sq.class_en |-> $past(sq.above_class)) // see RULE13
    else $error("class current without class voltage");
  AST_DONE_ORDER: assert property ($rose(sq.done) |-> $past(s_r.st) == SQ_CLASS) // see RULE3
    else $error("sequence done without classification");
  COV_MARK_LOOP: cover property (s_r.st == SQ_MARK ##[1:50] s_r.st == SQ_CLASS);
endmodule : pdhs_seq

// *** core/pdhs_core.sv ***
`timescale 1ns/1ps
module pdhs_core #(
  parameter int DWELL_CYC = pdhs_pkg::DWELL_CYC,
  parameter int SS_CYC = pdhs_pkg::SOFTSTART_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic PORT_ABOVE_RISE,
  input wire logic PORT_ABOVE_FALL,
  input wire logic PORT_IN_DET,
  input wire logic PORT_ABOVE_CLASS,
  input wire logic PORT_BELOW_MARK,
  input wire logic DROP_BELOW_ON,
  input wire logic DROP_ABOVE_OFF,
  input wire logic DROP_BELOW_RECLOSE,
  input wire logic RAIL_ABOVE_CLAMP,
  input wire logic RING_DETECT,
  input wire logic OVERCURRENT,
  input wire logic LOW_LOAD,
  input wire logic SHORT_CIRCUIT,
  input wire logic FREQ_PIN_AT_RAIL,
  output logic DET_SIG_EN,
  output logic CLASS_SINK_EN,
  output logic SW_CHARGE_EN,
  output logic SW_ON_EN,
  output logic SW_FAULT_EN,
  output logic SURGE_CLAMP_EN,
  output logic RING_SWITCH_EN,
  output logic CONV_RESET,
  output logic CONV_SOFTSTART,
  output logic CONV_SKIP,
  output logic OSC_FIXED_SEL
);
  import pdhs_pkg::*;

  localparam int DW = $clog2(DWELL_CYC + 1);
  localparam int SW = $clog2(SS_CYC + 1);

  typedef struct packed {
    pdhs_sw_e sw;
    logic lockout;
    logic [QUAL_W-1:0] qual_cnt;
    logic [DW-1:0] dwell_cnt;
    logic [SW-1:0] ss_cnt;
    logic crst;
    logic ss;
    logic permit;
    logic [EV_W-1:0] ev;
    logic ack;
    logic [31:0] dat;
    logic chg;
    logic on;
    logic flt;
    logic clamp;
    logic ring;
    logic skip;
    logic osc;
  } pdhs_core_s;

  pdhs_core_s r;
  pdhs_core_s nx;

  pdhs_seq_if sq_if ();

  assign sq_if.det_range = PORT_IN_DET;
  assign sq_if.above_class = PORT_ABOVE_CLASS;
  assign sq_if.below_mark = PORT_BELOW_MARK;
  assign sq_if.power_ok = PORT_ABOVE_RISE;

  pdhs_seq u_seq (
    .clk(CLK),
    .rst_n(RESET_N),
    .ce(CE),
    .sq(sq_if.seq)
  );

  logic req;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic qual_hit;
  logic dwell_done;
  logic pwr;

  always_comb begin
    nx = r;
    ev_set = '0;
    ev_clr = '0;
    req = WB_CYC_I && WB_STB_I && !r.ack;

    // Hysteresis between the two port comparators
    if (PORT_ABOVE_RISE) begin
      nx.lockout = 1'b0; // see RULE20
    end else if (!PORT_ABOVE_FALL) begin
      nx.lockout = 1'b1; // see RULE20
    end

    // Counters run on the free clock; comparators are sampled once per cycle
    qual_hit = DROP_ABOVE_OFF && (r.qual_cnt == QUAL_W'(QUAL_CYC - 1)); // see RULE21
    dwell_done = (r.dwell_cnt == DW'(DWELL_CYC - 1)); // see RULE21

    unique case (r.sw)
      SW_OFF: begin
        if (r.permit && sq_if.done) nx.sw = SW_CHARGE; // see RULE3 RULE4
      end
      SW_CHARGE: begin
        if (DROP_BELOW_ON) nx.sw = SW_ON; // see RULE6
      end
      SW_ON: begin
        if (qual_hit) nx.sw = SW_FAULT; // see RULE7
      end
      SW_FAULT: begin
        if (dwell_done && DROP_BELOW_RECLOSE) nx.sw = SW_ON; // see RULE9
      end
    endcase
    if (nx.lockout) nx.sw = SW_OFF; // see RULE1 RULE22

    if (nx.sw == SW_ON && DROP_ABOVE_OFF && !qual_hit) begin
      nx.qual_cnt = r.qual_cnt + 1'b1; // see RULE7
    end else begin
      nx.qual_cnt = '0;
    end
    if (nx.sw != SW_FAULT || r.sw != SW_FAULT) begin
      nx.dwell_cnt = '0;
    end else if (!dwell_done) begin
      nx.dwell_cnt = r.dwell_cnt + 1'b1; // see RULE9
    end

    // Only a fully closed switch powers the converter
    pwr = (nx.sw == SW_ON) && !nx.lockout; // see RULE20
    nx.crst = !pwr || OVERCURRENT; // see RULE15
    // Start-up is fixed: every exit from reset runs the same soft start
    if (nx.crst) begin
      nx.ss = 1'b0;
      nx.ss_cnt = '0;
    end else if (r.crst) begin
      nx.ss = 1'b1; // see RULE16 RULE17
      nx.ss_cnt = '0;
    end else if (r.ss) begin
      if (r.ss_cnt == SW'(SS_CYC - 1)) begin
        nx.ss = 1'b0; // see RULE17
      end else begin
        nx.ss_cnt = r.ss_cnt + 1'b1;
      end
    end
    nx.skip = !nx.crst && (LOW_LOAD || SHORT_CIRCUIT); // see RULE18
    nx.osc = FREQ_PIN_AT_RAIL; // see RULE19

    // All mode enables low means switch output and return rail are apart
    nx.chg = (nx.sw == SW_CHARGE); // see RULE2 RULE5
    nx.on = (nx.sw == SW_ON); // see RULE2
    nx.flt = (nx.sw == SW_FAULT); // see RULE8
    nx.clamp = RAIL_ABOVE_CLAMP && (nx.sw == SW_OFF); // see RULE10
    nx.ring = RING_DETECT; // see RULE11

    ev_set[EV_FAULT_BIT] = (nx.sw == SW_FAULT) && (r.sw != SW_FAULT);
    ev_set[EV_OC_BIT] = OVERCURRENT && !r.crst;
    ev_set[EV_LOCK_BIT] = nx.lockout && !r.lockout;
    ev_set[EV_ON_BIT] = (nx.sw == SW_ON) && (r.sw == SW_CHARGE);

    nx.ack = req;
    if (req) begin
      nx.dat = '0;
      if (WB_WE_I && WB_SEL_I[0]) begin
        if (WB_ADR_I == ADR_CTRL) nx.permit = WB_DAT_I[CTRL_PERMIT_BIT];
        if (WB_ADR_I == ADR_EVENTS) ev_clr = WB_DAT_I[EV_W-1:0];
      end else if (!WB_WE_I) begin
        unique case (WB_ADR_I)
          ADR_CTRL: nx.dat[CTRL_PERMIT_BIT] = r.permit;
          ADR_STATUS: begin
            nx.dat[ST_SW_LSB +: 2] = r.sw;
            nx.dat[ST_LOCK_BIT] = r.lockout;
            nx.dat[ST_SEQ_BIT] = sq_if.done;
            nx.dat[ST_CRST_BIT] = r.crst;
            nx.dat[ST_SS_BIT] = r.ss;
            nx.dat[ST_CLAMP_BIT] = r.clamp;
            nx.dat[ST_RING_BIT] = r.ring;
          end
          ADR_EVENTS: nx.dat[EV_W-1:0] = r.ev;
          default: nx.dat = '0;
        endcase
      end
    end
    // A new event beats a clear in the same cycle
    nx.ev = (r.ev & ~ev_clr) | ev_set;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '{sw: SW_OFF, lockout: 1'b1, crst: 1'b1, permit: CTRL_PERMIT_RST,
             default: '0};
    end else if (CE) begin
      r <= nx;
    end
  end

  assign WB_DAT_O = r.dat;
  assign WB_ACK_O = r.ack;
  assign DET_SIG_EN = sq_if.det_en;
  assign CLASS_SINK_EN = sq_if.class_en;
  assign SW_CHARGE_EN = r.chg;
  assign SW_ON_EN = r.on;
  assign SW_FAULT_EN = r.flt;
  assign SURGE_CLAMP_EN = r.clamp;
  assign RING_SWITCH_EN = r.ring;
  assign CONV_RESET = r.crst;
  assign CONV_SOFTSTART = r.ss;
  assign CONV_SKIP = r.skip;
  assign OSC_FIXED_SEL = r.osc;

  default clocking dcb @(posedge CLK iff CE); endclocking
  default disable iff (!RESET_N);

  int unsigned qual_exp;
  assign qual_exp = QUAL_CYC - 1;
  int unsigned dwell_exp;
  assign dwell_exp = DWELL_CYC - 1;

  AST_LOCK_OFF: assert property (r.lockout |-> r.sw == SW_OFF && !SW_ON_EN) // see RULE1
    else $error("switch active under lockout");
  AST_LOCK_FORCE: assert property ($rose(r.lockout) |-> r.sw == SW_OFF) // see RULE22
    else $error("lockout did not force off");
  AST_OFF_OPEN: assert property (r.sw == SW_OFF
      |-> !SW_CHARGE_EN && !SW_ON_EN && !SW_FAULT_EN) // see RULE2
    else $error("switch driven while off");
  AST_SEQ_FIRST: assert property (r.sw == SW_OFF ##1 r.sw != SW_OFF
      |-> $past(sq_if.done) && $past(r.permit)) // see RULE3
    else $error("switch closed before sequence");
  AST_CHARGE_FIRST: assert property (r.sw == SW_OFF
      |=> r.sw == SW_OFF || (r.sw == SW_CHARGE && SW_CHARGE_EN)) // see RULE4
    else $error("off skipped charge state");
  AST_CHARGE_MODE: assert property (r.sw == SW_CHARGE
      |-> SW_CHARGE_EN && !SW_ON_EN && !SW_FAULT_EN) // see RULE5
    else $error("charge state mode wrong");
  AST_TO_ON: assert property (r.sw == SW_CHARGE && DROP_BELOW_ON && !nx.lockout
      |=> r.sw == SW_ON) // see RULE6
    else $error("charge did not end at low drop");
  AST_QUAL: assert property (r.sw == SW_ON ##1 r.sw == SW_FAULT
      |-> $past(r.qual_cnt) == qual_exp && $past(DROP_ABOVE_OFF)) // see RULE7
    else $error("fault entered before qualifying time");
  AST_FAULT_MODE: assert property (r.sw == SW_FAULT
      |-> SW_FAULT_EN && !SW_ON_EN && !SW_CHARGE_EN) // see RULE8
    else $error("fault state mode wrong");
  AST_DWELL: assert property (r.sw == SW_FAULT ##1 r.sw == SW_ON
      |-> $past(r.dwell_cnt) == dwell_exp && $past(DROP_BELOW_RECLOSE)) // see RULE9
    else $error("fault left before dwell");
  AST_CLAMP: assert property (SURGE_CLAMP_EN
      |-> r.sw == SW_OFF && $past(RAIL_ABOVE_CLAMP)) // see RULE10
    else $error("clamp with switch closed");
  AST_RING: assert property (RING_DETECT |=> RING_SWITCH_EN) // see RULE11
    else $error("ringing switch not closed");
  AST_OC_RESET: assert property (OVERCURRENT |=> CONV_RESET && !CONV_SOFTSTART) // see RULE15
    else $error("converter ran during overcurrent");
  AST_SOFTSTART: assert property ($fell(CONV_RESET) |-> CONV_SOFTSTART) // see RULE16
    else $error("restart without soft start");
  AST_SKIP: assert property ((LOW_LOAD || SHORT_CIRCUIT) && !nx.crst
      |=> CONV_SKIP) // see RULE18
    else $error("no cycle skipping");
  AST_OSC: assert property (##1 OSC_FIXED_SEL == $past(FREQ_PIN_AT_RAIL)) // see RULE19
    else $error("oscillator select wrong");
  AST_HYST: assert property (!r.lockout && PORT_ABOVE_FALL |=> !r.lockout) // see RULE20
    else $error("lockout inside hysteresis");

  COV_REACH_ON: cover property (r.sw == SW_CHARGE ##1 r.sw == SW_ON);
  COV_FAULT_BACK: cover property (r.sw == SW_FAULT ##1 r.sw == SW_ON);
  COV_OC_RESTART: cover property ($fell(CONV_RESET) ##1 CONV_SOFTSTART);
  COV_EV_READ: cover property (WB_ACK_O && r.ev != '0);
endmodule : pdhs_core

// *** dv/pdhs_pse_model.sv ***
`timescale 1ns/1ps
module pdhs_pse_model #(
  parameter logic [9:0] RISE_DV = 10'h172,
  parameter logic [9:0] FALL_DV = 10'h140,
  parameter logic [9:0] DET_LO_DV = 10'h01b,
  parameter logic [9:0] DET_HI_DV = 10'h065,
  parameter logic [9:0] CLASS_DV = 10'h091,
  parameter logic [9:0] MARK_DV = 10'h064
) (
  input wire logic clk,
  output logic above_rise,
  output logic above_fall,
  output logic in_det,
  output logic above_class,
  output logic below_mark
);
  // Port voltage in tenths of a volt
  logic [9:0] volt_dv = 10'h000;

  // The cable only moves on a clock edge, so comparator edges never race the core
  task automatic set_volt(input logic [9:0] v);
    @(posedge clk);
    volt_dv <= v;
  endtask : set_volt

  always @(posedge clk) begin
    above_rise <= volt_dv >= RISE_DV;
    above_fall <= volt_dv > FALL_DV;
    in_det <= (volt_dv >= DET_LO_DV) && (volt_dv <= DET_HI_DV);
    above_class <= volt_dv > CLASS_DV;
    below_mark <= volt_dv < MARK_DV;
  end
endmodule : pdhs_pse_model

// *** dv/pdhs_core_test.sv ***
`timescale 1ns/1ps
module pdhs_core_test;
  import pdhs_pkg::*;
  localparam int DWELL = 20;
  localparam int SS = 10;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic CE = 1'b1;
  logic WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, WB_ACK_O;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
  logic PORT_ABOVE_RISE, PORT_ABOVE_FALL, PORT_IN_DET, PORT_ABOVE_CLASS, PORT_BELOW_MARK;
  logic DROP_BELOW_ON = 1'b0, DROP_ABOVE_OFF = 1'b0, DROP_BELOW_RECLOSE = 1'b0;
  logic RAIL_ABOVE_CLAMP = 1'b0, RING_DETECT = 1'b0, OVERCURRENT = 1'b0;
  logic LOW_LOAD = 1'b0, SHORT_CIRCUIT = 1'b0, FREQ_PIN_AT_RAIL = 1'b0;
  logic DET_SIG_EN, CLASS_SINK_EN, SW_CHARGE_EN, SW_ON_EN, SW_FAULT_EN, SURGE_CLAMP_EN;
  logic RING_SWITCH_EN, CONV_RESET, CONV_SOFTSTART, CONV_SKIP, OSC_FIXED_SEL;
  logic [2:0] sw;
  int n_errors = 0;
  int n_tests = 0;
  int n;

  assign sw = {SW_FAULT_EN, SW_ON_EN, SW_CHARGE_EN};

  always #25 CLK = ~CLK;

  pdhs_pse_model pdhs_pse_model_inst (.clk(CLK), .above_rise(PORT_ABOVE_RISE),
    .above_fall(PORT_ABOVE_FALL), .in_det(PORT_IN_DET), .above_class(PORT_ABOVE_CLASS),
    .below_mark(PORT_BELOW_MARK));

  pdhs_core #(.DWELL_CYC(DWELL), .SS_CYC(SS)) pdhs_core_inst (.CLK, .RESET_N, .CE,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O,
    .PORT_ABOVE_RISE, .PORT_ABOVE_FALL, .PORT_IN_DET, .PORT_ABOVE_CLASS, .PORT_BELOW_MARK,
    .DROP_BELOW_ON, .DROP_ABOVE_OFF, .DROP_BELOW_RECLOSE, .RAIL_ABOVE_CLAMP, .RING_DETECT,
    .OVERCURRENT, .LOW_LOAD, .SHORT_CIRCUIT, .FREQ_PIN_AT_RAIL, .DET_SIG_EN, .CLASS_SINK_EN,
    .SW_CHARGE_EN, .SW_ON_EN, .SW_FAULT_EN, .SURGE_CLAMP_EN, .RING_SWITCH_EN, .CONV_RESET,
    .CONV_SOFTSTART, .CONV_SKIP, .OSC_FIXED_SEL);

  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic settle(input int cycles);
    repeat (cycles) @(posedge CLK);
    #1;
  endtask : settle

  // One classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= sel;
    // No limit here: a lost ack is left to the watchdog
    do begin
      @(posedge CLK);
    end while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
    // Slave must drop ack in the cycle after it gave it
    @(posedge CLK);
    chk("bus ack", 32'h0, {31'h0, WB_ACK_O});
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                    input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk(what, exp, q & mask);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] q;
    wb(1'b1, a, d, sel, q);
  endtask : wr

  initial begin
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    settle(1);
    chk("conv reset", 32'h1, CONV_RESET);
    chk("switch", 32'h0, sw);
    rd(ADR_CTRL, 32'hffffffff, 32'h1, "ctrl");
    rd(ADR_STATUS, 32'h0f, 32'h4, "status");
    rd(8'h0c, 32'hffffffff, 32'h0, "unmapped");
    // Full voltage with no handshake must not close the switch
    @(posedge CLK);
    RAIL_ABOVE_CLAMP <= 1'b1;
    pdhs_pse_model_inst.set_volt(10'h190);
    settle(6);
    chk("switch", 32'h0, sw);
    rd(ADR_STATUS, 32'h0f, 32'h0, "status");
    chk("surge", 32'h1, SURGE_CLAMP_EN);
    pdhs_pse_model_inst.set_volt(10'h000);
    settle(5);
    wr(ADR_EVENTS, 32'hf, 4'h1);
    // Two-event handshake: detect, class, mark, class, power
    pdhs_pse_model_inst.set_volt(10'h03c);
    settle(4);
    chk("det", 32'h1, DET_SIG_EN);
    pdhs_pse_model_inst.set_volt(10'h0b4);
    settle(4);
    chk("class", 32'h1, CLASS_SINK_EN);
    chk("det", 32'h0, DET_SIG_EN);
    pdhs_pse_model_inst.set_volt(10'h050);
    settle(4);
    chk("class", 32'h0, CLASS_SINK_EN);
    pdhs_pse_model_inst.set_volt(10'h0b4);
    settle(4);
    chk("class", 32'h1, CLASS_SINK_EN);
    pdhs_pse_model_inst.set_volt(10'h1e0);
    settle(5);
    chk("class", 32'h0, CLASS_SINK_EN);
    chk("switch", 32'h1, sw);
    chk("conv reset", 32'h1, CONV_RESET);
    chk("surge", 32'h0, SURGE_CLAMP_EN);
    @(posedge CLK);
    DROP_BELOW_ON <= 1'b1;
    settle(2);
    chk("switch", 32'h2, sw);
    settle(2);
    chk("conv reset", 32'h0, CONV_RESET);
    chk("soft start", 32'h1, CONV_SOFTSTART);
    settle(SS + 2);
    chk("soft start", 32'h0, CONV_SOFTSTART);
    // Overload just short of the qualifying time, then long enough
    @(posedge CLK);
    DROP_ABOVE_OFF <= 1'b1;
    repeat (2790) @(posedge CLK);
    DROP_ABOVE_OFF <= 1'b0;
    settle(2);
    chk("switch", 32'h2, sw);
    @(posedge CLK);
    DROP_ABOVE_OFF <= 1'b1;
    repeat (2790) @(posedge CLK);
    n = 0;
    while (SW_FAULT_EN !== 1'b1 && n < 40) begin
      @(posedge CLK);
      n++;
    end
    DROP_ABOVE_OFF <= 1'b0;
    DROP_BELOW_RECLOSE <= 1'b1;
    chk("qualify", 32'h1, {31'h0, n >= 8 && n <= 15});
    settle(2);
    chk("switch", 32'h4, sw);
    settle(DWELL - 6);
    chk("switch", 32'h4, sw);
    settle(8);
    chk("switch", 32'h2, sw);
    rd(ADR_EVENTS, 32'hf, 32'h9, "events");
    wr(ADR_EVENTS, 32'h9, 4'h1);
    rd(ADR_EVENTS, 32'hf, 32'h0, "events");
    // Overcurrent holds the converter, release restarts through soft start
    @(posedge CLK);
    OVERCURRENT <= 1'b1;
    settle(3);
    chk("conv reset", 32'h1, CONV_RESET);
    settle(5);
    chk("conv reset", 32'h1, CONV_RESET);
    rd(ADR_EVENTS, 32'h2, 32'h2, "events");
    @(posedge CLK);
    OVERCURRENT <= 1'b0;
    settle(3);
    chk("conv reset", 32'h0, CONV_RESET);
    chk("soft start", 32'h1, CONV_SOFTSTART);
    settle(SS + 2);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      {LOW_LOAD, SHORT_CIRCUIT} <= i[1:0];
      FREQ_PIN_AT_RAIL <= i[0];
      RING_DETECT <= i[1];
      settle(3);
      chk("skip", {31'h0, i != 0}, CONV_SKIP);
      chk("osc", {31'h0, i[0]}, OSC_FIXED_SEL);
      chk("ring", {31'h0, i[1]}, RING_SWITCH_EN);
    end
    // Clock enable low must freeze every register, outputs included
    @(posedge CLK);
    CE <= 1'b0;
    RING_DETECT <= 1'b0;
    settle(3);
    chk("ring frozen", 32'h1, RING_SWITCH_EN);
    @(posedge CLK);
    CE <= 1'b1;
    settle(2);
    chk("ring", 32'h0, RING_SWITCH_EN);
    // Lockout and its hysteresis
    pdhs_pse_model_inst.set_volt(10'h136);
    settle(4);
    chk("switch", 32'h0, sw);
    chk("surge", 32'h1, SURGE_CLAMP_EN);
    chk("conv reset", 32'h1, CONV_RESET);
    rd(ADR_EVENTS, 32'h4, 32'h4, "events");
    pdhs_pse_model_inst.set_volt(10'h15e);
    settle(4);
    chk("switch", 32'h0, sw);
    // Rail back under the clamp level; drop high so the next close stays in charge
    @(posedge CLK);
    RAIL_ABOVE_CLAMP <= 1'b0;
    DROP_BELOW_ON <= 1'b0;
    DROP_BELOW_RECLOSE <= 1'b0;
    settle(2);
    chk("surge", 32'h0, SURGE_CLAMP_EN);
    wr(ADR_CTRL, 32'h0, 4'h1);
    pdhs_pse_model_inst.set_volt(10'h190);
    settle(5);
    chk("switch", 32'h0, sw);
    wr(ADR_CTRL, 32'h1, 4'h0);
    settle(3);
    chk("switch", 32'h0, sw);
    wr(ADR_CTRL, 32'h1, 4'h1);
    settle(4);
    chk("switch", 32'h1, sw);
    summarize;
  end

  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    $display("BAD watchdog expected finish seen hang");
    summarize;
  end
endmodule : pdhs_core_test
